// ---- rtl/iump_cmd_reg.sv ----
// iump_cmd_reg: strobed holding register for one command field
// assumes the strobe and data come from logic on the same clock
`timescale 1ns/1ps
module iump_cmd_reg #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and resets
    input wire logic clk,
    input wire logic arst_n,
    input wire logic node_reset,
    // capture
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ==================================================================
    // holding flop: node reset acts synchronously so it is never glitchy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= RST;
        end else if (node_reset) begin
            q <= RST; // RULE3
        end else if (load) begin
            q <= d; // RULE11
        end
    end

endmodule // iump_cmd_reg

// ---- rtl/iump_input_unit_mode_port.sv ----
// iump_input_unit_mode_port: command side of the input unit
// assumes the mode control unit drives all inputs from clk
// assumes node reset is a level from that same unit, sampled on clk
// Functional notes
// RULE1 - single clock, rising edge only
// RULE2 - no reliance on clock duty cycle
// RULE3 - node reset returns to default at once
// RULE4 - node reset does not imply controller reset
// RULE5 - kind and identifier static after first strobe
// RULE6 - major mode sampled only on ready strobe
// RULE7 - minor mode decoded into eight spans
// RULE8 - cycle index meaningful only in clique join
// RULE9 - idle outputs without default are don't care
// RULE10 - controller strobes ready with each command
// RULE11 - command held until next strobe or reset
`timescale 1ns/1ps
module iump_input_unit_mode_port
    import iump_pkg::*;
(
    // clock and resets
    input wire logic clk,
    input wire logic arst_n,
    input wire logic node_reset,
    // static configuration
    input wire logic node_kind_cfg,
    input wire logic [IUMP_ID_W-1:0] node_identifier_cfg,
    // mode command
    input wire logic mcu_ready,
    input wire logic [2:0] major_mode_cmd,
    input wire logic [2:0] minor_mode_cmd,
    input wire logic diag_cycle_cmd,
    // held configuration
    output logic node_kind,
    output logic [IUMP_ID_W-1:0] node_identifier,
    output logic cfg_locked,
    // held command
    output logic [2:0] major_mode,
    output logic [2:0] minor_mode,
    output logic diag_cycle,
    output logic diag_cycle_valid,
    output logic cmd_new,
    // decoded minor mode, one-hot
    output logic [7:0] minor_onehot
);

    // ==================================================================
    // configuration latch: captured on first strobe only, and kept over
    // node reset since the controller may not be reset with us
    logic cfg_locked_ff;
    logic node_kind_ff;
    logic [IUMP_ID_W-1:0] node_id_ff;

    always_ff @(posedge clk or negedge arst_n) begin // RULE1
        if (!arst_n) begin
            cfg_locked_ff <= 1'b0;
            node_kind_ff <= IUMP_KIND_RST;
            node_id_ff <= IUMP_ID_RST;
        end else if (mcu_ready && !cfg_locked_ff) begin // RULE4
            cfg_locked_ff <= 1'b1; // RULE5
            node_kind_ff <= node_kind_cfg;
            node_id_ff <= node_identifier_cfg;
        end
    end
    // node reset is deliberately not an input of this latch

    // ==================================================================
    // command fields, each a strobed register; all single-edge, so any
    // duty cycle works
    logic [2:0] major_q;
    logic [2:0] minor_q;
    logic cyc_q;
    logic cmd_new_ff;

    iump_cmd_reg #(.W(3), .RST(IUMP_MAJ_RST)) u_major (
        .clk(clk), .arst_n(arst_n), .node_reset(node_reset),
        .load(mcu_ready), .d(major_mode_cmd), .q(major_q) // RULE6
    );
    iump_cmd_reg #(.W(3), .RST(IUMP_MIN_RST)) u_minor (
        .clk(clk), .arst_n(arst_n), .node_reset(node_reset),
        .load(mcu_ready), .d(minor_mode_cmd), .q(minor_q)
    );
    // the index is zeroed at capture outside clique join, so the held
    // value is already the masked one and leaves straight from a flop
    iump_cmd_reg #(.W(1), .RST(1'b0)) u_cycle (
        .clk(clk), .arst_n(arst_n), .node_reset(node_reset),
        .load(mcu_ready),
        .d((major_mode_cmd == IUMP_MAJ_CLQ_JOIN) && diag_cycle_cmd), // RULE8
        .q(cyc_q)
    );

    // new-command pulse, one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin // RULE2
        if (!arst_n) begin
            cmd_new_ff <= 1'b0;
        end else begin
            cmd_new_ff <= mcu_ready && !node_reset; // RULE10
        end
    end

    // ==================================================================
    // minor mode decode, one flop per span loaded beside minor_q, so the
    // one-hot word is registered instead of decoded after the flops
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_dec
            iump_cmd_reg #(.W(1), .RST(1'(IUMP_MIN_RST == 3'(gi)))) u_bit (
                .clk(clk), .arst_n(arst_n), .node_reset(node_reset),
                .load(mcu_ready), .d(minor_mode_cmd == 3'(gi)), // RULE7
                .q(minor_onehot[gi])
            );
        end
    endgenerate

    // ==================================================================
    // outputs; the cycle index is zero outside clique join (RULE9 lets
    // it be anything, zero keeps it a plain flop)
    assign node_kind = node_kind_ff;
    assign node_identifier = node_id_ff;
    assign cfg_locked = cfg_locked_ff;
    assign major_mode = major_q;
    assign minor_mode = minor_q;
    assign diag_cycle_valid = (major_q == IUMP_MAJ_CLQ_JOIN); // RULE8
    assign diag_cycle = cyc_q; // RULE9
    assign cmd_new = cmd_new_ff;

    // ==================================================================
    // command sequences shared by the checks below
    // a strobe that the port takes: ready high, no node reset beside it
    sequence s_taken;
        mcu_ready && !node_reset;
    endsequence
    // a taken strobe followed by a quiet ready line
    sequence s_taken_then_quiet;
        s_taken ##1 !mcu_ready;
    endsequence
    // the new-command flag stands for exactly one cycle
    sequence s_new_once;
        cmd_new ##1 !cmd_new;
    endsequence
    // a taken strobe that carries a clique join command
    sequence s_join_taken;
        s_taken ##0 (major_mode_cmd == IUMP_MAJ_CLQ_JOIN);
    endsequence
    // a taken strobe for any other major mode
    sequence s_other_taken;
        s_taken ##0 (major_mode_cmd != IUMP_MAJ_CLQ_JOIN);
    endsequence

    // ==================================================================
    // checks
    chk_major_capture: assert property ( // RULE6
        @(posedge clk) disable iff (!arst_n)
        mcu_ready && !node_reset |=> major_mode == $past(major_mode_cmd))
        else $error("major mode not captured");
    chk_major_hold: assert property ( // RULE11
        @(posedge clk) disable iff (!arst_n)
        !mcu_ready && !node_reset |=> $stable(major_mode))
        else $error("major mode changed without strobe");
    chk_minor_capture: assert property ( // RULE7
        @(posedge clk) disable iff (!arst_n)
        mcu_ready && !node_reset |=> minor_mode == $past(minor_mode_cmd))
        else $error("minor mode not captured");
    chk_reset_default: assert property ( // RULE3
        @(posedge clk) disable iff (!arst_n)
        node_reset |=> major_mode == IUMP_MAJ_RST &&
        minor_mode == IUMP_MIN_RST && !cmd_new)
        else $error("node reset did not restore defaults");
    chk_cfg_static: assert property ( // RULE5
        @(posedge clk) disable iff (!arst_n)
        cfg_locked |=> $stable(node_identifier) && $stable(node_kind))
        else $error("configuration changed after lock");
    chk_cfg_survive: assert property ( // RULE4
        @(posedge clk) disable iff (!arst_n)
        cfg_locked && node_reset |=> cfg_locked)
        else $error("node reset cleared configuration");
    chk_cycle_gate: assert property ( // RULE8
        @(posedge clk) disable iff (!arst_n)
        major_mode != IUMP_MAJ_CLQ_JOIN |-> !diag_cycle)
        else $error("cycle index outside clique join");
    chk_onehot_dec: assert property ( // RULE7
        @(posedge clk) disable iff (!arst_n)
        minor_onehot == (8'h01 << minor_mode))
        else $error("minor decode wrong");
    chk_new_pulse: assert property ( // RULE10
        @(posedge clk) disable iff (!arst_n)
        s_taken_then_quiet |-> s_new_once)
        else $error("new command pulse wrong");

    // held fields stay put between strobes
    chk_minor_hold: assert property ( // RULE11
        @(posedge clk) disable iff (!arst_n)
        !mcu_ready && !node_reset |=> $stable(minor_mode))
        else $error("minor mode changed without strobe");
    chk_cycle_hold: assert property ( // RULE11
        @(posedge clk) disable iff (!arst_n)
        !mcu_ready && !node_reset |=> $stable(diag_cycle))
        else $error("cycle index changed without strobe");

    // cycle index taken only with a clique join command
    chk_cycle_capture: assert property ( // RULE8
        @(posedge clk) disable iff (!arst_n)
        s_join_taken |=> diag_cycle == $past(diag_cycle_cmd))
        else $error("cycle index not captured in clique join");
    chk_cycle_other: assert property ( // RULE8
        @(posedge clk) disable iff (!arst_n)
        s_other_taken |=> !diag_cycle)
        else $error("cycle index taken outside clique join");

    // configuration is caught once and then kept
    chk_cfg_capture: assert property ( // RULE5
        @(posedge clk) disable iff (!arst_n)
        mcu_ready && !cfg_locked |=> cfg_locked &&
        node_identifier == $past(node_identifier_cfg) &&
        node_kind == $past(node_kind_cfg))
        else $error("configuration not captured on first strobe");
    chk_cfg_lock_stays: assert property ( // RULE5
        @(posedge clk) disable iff (!arst_n)
        cfg_locked |=> cfg_locked)
        else $error("configuration lock dropped");
    chk_cfg_wait: assert property ( // RULE5
        @(posedge clk) disable iff (!arst_n)
        !cfg_locked && !mcu_ready |=> !cfg_locked)
        else $error("configuration locked without strobe");

    // new-command flag follows the taken strobes only
    chk_new_taken: assert property ( // RULE10
        @(posedge clk) disable iff (!arst_n)
        s_taken |=> cmd_new)
        else $error("new command flag missing after strobe");
    chk_new_idle: assert property ( // RULE10
        @(posedge clk) disable iff (!arst_n)
        !mcu_ready || node_reset |=> !cmd_new)
        else $error("new command flag without taken strobe");

    // decode stays one-hot, node reset clears the remaining fields
    chk_onehot_one: assert property ( // RULE7
        @(posedge clk) disable iff (!arst_n)
        $onehot(minor_onehot))
        else $error("minor decode not one-hot");
    chk_reset_cycle: assert property ( // RULE3
        @(posedge clk) disable iff (!arst_n)
        node_reset |=> !diag_cycle &&
        minor_onehot == (8'h01 << IUMP_MIN_RST))
        else $error("node reset left cycle or decode set");

endmodule // iump_input_unit_mode_port

// ---- rtl/iump_pkg.sv ----
// package for the input unit mode command port: encodings and widths
// assumes a single clock domain shared with the mode control unit
package iump_pkg;

    // ==================================================================
    // sizes
    localparam int unsigned IUMP_NUM_BUS_NODES = 4;
    localparam int unsigned IUMP_NUM_OPP_NODES = 4;
    localparam int unsigned IUMP_MAX_ID = (IUMP_NUM_BUS_NODES >
        IUMP_NUM_OPP_NODES) ? IUMP_NUM_BUS_NODES : IUMP_NUM_OPP_NODES;
    localparam int unsigned IUMP_ID_W = $clog2(IUMP_MAX_ID + 1);
    localparam logic [IUMP_ID_W-1:0] IUMP_ID_RST = '0;

    // ==================================================================
    // enumerations
    typedef enum logic [0:0] {
        IUMP_KIND_BUS_IF = 1'b0,
        IUMP_KIND_REDUND = 1'b1
    } iump_kind_t;

    typedef enum logic [2:0] {
        IUMP_MAJ_SELF_TEST   = 3'h0,
        IUMP_MAJ_CLQ_DETECT  = 3'h1,
        IUMP_MAJ_CLQ_INIT    = 3'h2,
        IUMP_MAJ_CLQ_JOIN    = 3'h3,
        IUMP_MAJ_CLQ_PRESERV = 3'h4
    } iump_major_t;

    typedef enum logic [2:0] {
        IUMP_MIN_RESET       = 3'h0,
        IUMP_MIN_SELF_TEST   = 3'h1,
        IUMP_MIN_LDIAG_CAPT  = 3'h2,
        IUMP_MIN_IDIAG_ISYNC = 3'h3,
        IUMP_MIN_COLL_DIAG   = 3'h4,
        IUMP_MIN_SCHED_UPD   = 3'h5,
        IUMP_MIN_PE_COMM     = 3'h6,
        IUMP_MIN_SYNC_PRES   = 3'h7
    } iump_minor_t;

    localparam iump_major_t IUMP_MAJ_RST = IUMP_MAJ_SELF_TEST;
    localparam iump_minor_t IUMP_MIN_RST = IUMP_MIN_RESET;
    localparam iump_kind_t IUMP_KIND_RST = IUMP_KIND_BUS_IF;

endpackage

// ---- verification/iump_mcu_model.sv ----
// mode control unit stand-in for the input unit command port
// assumes the bench hands it a request and command on clk edges
`timescale 1ns/1ps
module iump_mcu_model (
    // clock
    input wire logic clk,
    // bench request
    input wire logic req,
    input wire logic [6:0] cmd_in,
    // mode command
    output logic mcu_ready,
    output logic [6:0] cmd_out
);
    // ====================================================
    // strobe only with a fresh command; fields scramble between
    // strobes because they carry no meaning then
    always_ff @(posedge clk) begin
        mcu_ready <= req;
        cmd_out <= req ? cmd_in : ~cmd_out;
    end
endmodule // iump_mcu_model

// ---- verification/testbench.sv ----
// self-checking bench for the input unit mode command port
// assumes one 125 MHz clock and the mode unit stand-in
`timescale 1ns/1ps
module testbench;
    import iump_pkg::*;
    logic clk, arst_n, node_reset, node_kind_cfg, req, mcu_ready;
    logic node_kind, cfg_locked, diag_cycle, diag_cycle_valid, cmd_new;
    logic [2:0] node_identifier_cfg, node_identifier, major_mode, minor_mode;
    logic [6:0] cmd, cmd_out, cmd_ff;
    logic [4:0] cfg_ff;
    logic [7:0] minor_onehot;
    logic [31:0] v;
    logic new_ff;
    integer seed = 32'hc251_8ad5;
    int num_errors = 0, n_compared = 0, cycles = 0;

    iump_mcu_model mcu (.clk(clk), .req(req), .cmd_in(cmd),
        .mcu_ready(mcu_ready), .cmd_out(cmd_out));
    iump_input_unit_mode_port uut (.clk(clk), .arst_n(arst_n),
        .node_reset(node_reset), .node_kind_cfg(node_kind_cfg),
        .node_identifier_cfg(node_identifier_cfg), .mcu_ready(mcu_ready),
        .major_mode_cmd(cmd_out[6:4]), .minor_mode_cmd(cmd_out[3:1]),
        .diag_cycle_cmd(cmd_out[0]), .node_kind(node_kind),
        .node_identifier(node_identifier), .cfg_locked(cfg_locked),
        .major_mode(major_mode), .minor_mode(minor_mode),
        .diag_cycle(diag_cycle), .diag_cycle_valid(diag_cycle_valid),
        .cmd_new(cmd_new), .minor_onehot(minor_onehot));

    // ====================================================
    // expected outputs packed in port order
    function automatic logic [21:0] expect_out(input logic [4:0] c,
        input logic [6:0] m, input logic n);
        expect_out = {c[3], c[2:0], c[4], m, m[6:4] == 3'h3, n,
            8'h01 << m[3:1]};
    endfunction

    // ====================================================
    // reference state; config survives node reset by design choice
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff <= '0;
            cmd_ff <= '0;
            new_ff <= 1'b0;
        end else begin
            new_ff <= mcu_ready && !node_reset;
            if (mcu_ready && !cfg_ff[4])
                cfg_ff <= {1'b1, node_kind_cfg, node_identifier_cfg};
            if (node_reset)
                cmd_ff <= '0;
            else if (mcu_ready)
                cmd_ff <= {cmd_out[6:1],
                    cmd_out[6:4] == 3'h3 && cmd_out[0]};
        end
    end

    // ====================================================
    // compare on the falling edge, once all updates have landed
    always @(negedge clk) begin
        n_compared++;
        if ({node_kind, node_identifier, cfg_locked, major_mode, minor_mode,
            diag_cycle, diag_cycle_valid, cmd_new, minor_onehot}
            !== expect_out(cfg_ff, cmd_ff, new_ff)) begin
            num_errors++;
            $display("Error %0t: outputs differ from expected", $time);
        end
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic drive(input logic r, input logic nr, input logic [6:0] c);
        @(posedge clk);
        req <= r;
        node_reset <= nr;
        cmd <= c;
    endtask

    task automatic end_sim();
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        arst_n = 1'b0;
        node_reset = 1'b0;
        req = 1'b0;
        cmd = '0;
        node_kind_cfg = 1'b1;
        node_identifier_cfg = 3'h4;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        // back-to-back strobes through every minor and major code
        for (int i = 0; i < 8; i++)
            drive(1'b1, 1'b0, {3'(i % 5), 3'(i), 1'b1});
        // two rounds of random traffic, config wiggling after lock, a reset after each round
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 300; i++) begin
                v = $random(seed);
                drive(v[8], v[15:12] == 4'h0,
                    {v[2:0] % 3'h5, v[5:3], v[6]});
                node_kind_cfg <= v[9];
                node_identifier_cfg <= 3'(v[11:10]) + 3'h1;
            end
            // quiet the strobe so no command meets the reset release edge
            drive(1'b0, 1'b0, '0);
            @(posedge clk);
            arst_n <= 1'b0;
            @(posedge clk);
            arst_n <= 1'b1;
        end
        repeat (3) @(posedge clk);
        end_sim();
    end
endmodule // testbench
